// file: swm_cfg.svh
/*
 Timing constants and command codes for the single-wire bus master.
 Assumes a 10 MHz system clock; included by the package, the master and its bench.
*/
`ifndef SWM_CFG_SVH
`define SWM_CFG_SVH

`define SWM_CLK_MHZ 10
// Times in microseconds
`define SWM_T_RST_US 480
`define SWM_T_PRES_WAIT_US 70
`define SWM_T_RST_TAIL_US 410
`define SWM_T_SLOT_US 65
`define SWM_T_REC_US 2
`define SWM_T_W1_LOW_US 6
`define SWM_T_RD_LOW_US 1
`define SWM_T_RD_SAMPLE_US 13
`define SWM_T_SPU_ON_US 5
// Cycle counts derived from the times
`define SWM_CYC(us) ((us) * `SWM_CLK_MHZ)
`define SWM_CMD_CONVERT 8'h44
`define SWM_CMD_READ_PAD 8'hBE
`define SWM_CMD_WRITE_PAD 8'h4E
`define SWM_CMD_COPY_PAD 8'h48
`define SWM_CMD_RELOAD 8'hB8
`define SWM_CMD_READ_POWER 8'hB4
`define SWM_CNT_W 14

`endif

// file: swm_master.sv
/*
 Bus master for a single-wire temperature sensor link.
 Assumes the line has an external pull-up and the testbench resolves the
 open-drain wire from line_oe and the sensor's pull_low, both driving low.
 Results leave through a two-entry buffer so a stalled consumer loses none.
//
// Overview of operation
// [R1] Reset pulse holds line low 480 us
// [R2] Sensor presence sampled after reset release
// [R3] Master originates every slot and reset
// [R4] One bit per time slot
// [R5] Write slots 60 us, 1 us recovery
// [R6] Write one releases within 15 us
// [R7] Write zero holds low whole slot
// [R8] Sensor samples writes 15 to 60 us
// [R9] Read slots follow read commands immediately
// [R10] Read slot low 1 us, 60 us long
// [R11] Sensor drives zero low, one high
// [R12] Sensor read data valid 15 us
// [R13] Master releases and samples within 15 us
// [R14] Short init, sample late in window
// [R15] Convert command, status via read slots
// [R16] Read scratchpad returns up to nine bytes
// [R17] Write scratchpad takes three bytes
// [R18] Copy scratchpad, no data follows
// [R19] Reload from nonvolatile reports status
// [R20] Power mode reported in read slot
// [R21] Strong pull-up, no other activity
// [R22] Reset may cut any transfer
// [R23] Write-pad sends all three bytes first
// [R24] Bytes sent least significant bit first
// [R25] Conversion status zero busy, one done
// [R26] Line-powered sensor pulls power slot low
// [R27] Strong pull-up within 10 us
// [R28] Long low is reset anywhere
// [R29] Windows timed from local clock
*/
`timescale 1ns/1ps
`default_nettype none
`include "swm_cfg.svh"

module swm_master #(
   parameter int CNT_W = `SWM_CNT_W
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire swm_pkg::swm_req_t req,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output swm_pkg::swm_rsp_t rsp,
   input wire logic line_in,
   output logic line_oe,
   output logic spu_oe,
   output logic busy
);
   localparam logic [CNT_W-1:0] C_RST =
      CNT_W'(`SWM_CYC(`SWM_T_RST_US));
   localparam logic [CNT_W-1:0] C_PRES =
      CNT_W'(`SWM_CYC(`SWM_T_PRES_WAIT_US));
   localparam logic [CNT_W-1:0] C_TAIL =
      CNT_W'(`SWM_CYC(`SWM_T_RST_TAIL_US));
   localparam logic [CNT_W-1:0] C_SLOT =
      CNT_W'(`SWM_CYC(`SWM_T_SLOT_US));
   localparam logic [CNT_W-1:0] C_REC =
      CNT_W'(`SWM_CYC(`SWM_T_REC_US));
   localparam logic [CNT_W-1:0] C_W1 =
      CNT_W'(`SWM_CYC(`SWM_T_W1_LOW_US));
   localparam logic [CNT_W-1:0] C_RDL =
      CNT_W'(`SWM_CYC(`SWM_T_RD_LOW_US));
   localparam logic [CNT_W-1:0] C_SMP =
      CNT_W'(`SWM_CYC(`SWM_T_RD_SAMPLE_US));
   localparam logic [CNT_W-1:0] C_SPU =
      CNT_W'(`SWM_CYC(`SWM_T_SPU_ON_US));

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RST_LOW,
      ST_RST_WAIT,
      ST_RST_TAIL,
      ST_SLOT,
      ST_RECOVER,
      ST_SPU_WAIT,
      ST_PULL
   } swm_state_t;

   swm_state_t state;
   swm_pkg::swm_op_t op;
   logic [CNT_W-1:0] cnt;
   logic [15:0] hold_ms;
   logic [7:0] shreg;
   logic [2:0] bit_idx;
   logic last_bit;
   logic pres;
   logic smp_bit;
   logic out_push;
   swm_pkg::swm_rsp_t out_word;
   logic buf_ready;
   logic [CNT_W-1:0] ms_cnt;
   logic [CNT_W-1:0] low_run;

   wire cnt_done = (cnt == '0); // [R29]
   wire is_read = (op == swm_pkg::SWM_OP_READ_BYTE) ||
                  (op == swm_pkg::SWM_OP_READ_BIT);
   wire [CNT_W-1:0] low_len = is_read ? C_RDL :
                              (shreg[0] ? C_W1 : C_SLOT); // [R6] [R7] [R10]
   wire [CNT_W-1:0] slot_pos = C_SLOT - cnt;
   wire drive_low = (state == ST_RST_LOW) ||
                    (state == ST_SLOT && slot_pos < low_len); // [R3]
   // Only read slots capture the line; write slots leave smp_bit alone
   wire sample_now = (state == ST_SLOT) && is_read &&
                     (slot_pos == C_SMP); // [R12] [R13] [R14]
   // A request is taken only on an edge where req_ready was shown high
   wire take_req = (state == ST_IDLE) && req_valid && req_ready &&
                   buf_ready;
   wire [7:0] next_shreg = {smp_bit, shreg[7:1]};

   // Output drive comes from flops; line_oe lags drive_low by one cycle,
   // which is far below every window tolerance.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         line_oe <= 1'b0;
         smp_bit <= 1'b1;
      end else begin
         line_oe <= drive_low;
         if (sample_now) begin
            smp_bit <= line_in; // [R11] [R25] [R26]
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         op <= swm_pkg::SWM_OP_RESET;
         cnt <= '0;
         hold_ms <= 16'h0000;
         ms_cnt <= '0;
         shreg <= 8'h00;
         bit_idx <= 3'h0;
         last_bit <= 1'b0;
         pres <= 1'b0;
         spu_oe <= 1'b0;
         out_push <= 1'b0;
         out_word <= '0;
      end else begin
         out_push <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take_req) begin
                  op <= req.op;
                  shreg <= (req.op == swm_pkg::SWM_OP_WRITE_BYTE) ?
                           req.data : 8'hFF;
                  bit_idx <= 3'h0;
                  last_bit <= (req.op == swm_pkg::SWM_OP_READ_BIT);
                  hold_ms <= req.hold;
                  case (req.op)
                     swm_pkg::SWM_OP_RESET: begin
                        state <= ST_RST_LOW; // [R1] [R22] [R28]
                        cnt <= C_RST;
                     end
                     swm_pkg::SWM_OP_STRONG_PULL: begin
                        state <= ST_SPU_WAIT; // [R27]
                        cnt <= C_SPU;
                     end
                     default: begin
                        state <= ST_SLOT; // [R9]
                        cnt <= C_SLOT;
                     end
                  endcase
               end
            end
            ST_RST_LOW: begin
               cnt <= cnt - 1'b1;
               if (cnt_done) begin
                  state <= ST_RST_WAIT;
                  cnt <= C_PRES;
               end
            end
            ST_RST_WAIT: begin
               cnt <= cnt - 1'b1;
               if (cnt_done) begin
                  pres <= ~line_in; // [R2]
                  state <= ST_RST_TAIL;
                  cnt <= C_TAIL;
               end
            end
            ST_RST_TAIL: begin
               cnt <= cnt - 1'b1;
               if (cnt_done) begin
                  out_word <= '{presence: pres, data: 8'h00,
                                is_reset: 1'b1};
                  out_push <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_SLOT: begin
               cnt <= cnt - 1'b1; // [R4] [R5]
               if (cnt_done) begin
                  state <= ST_RECOVER;
                  cnt <= C_REC;
               end
            end
            ST_RECOVER: begin
               cnt <= cnt - 1'b1;
               if (cnt_done) begin
                  shreg <= next_shreg; // [R24]
                  bit_idx <= bit_idx + 3'h1;
                  if (last_bit || bit_idx == 3'h7) begin
                     out_word <= '{presence: 1'b0,
                        data: last_bit ? {7'h00, smp_bit} : next_shreg,
                        is_reset: 1'b0};
                     out_push <= is_read;
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_SLOT;
                     cnt <= C_SLOT;
                  end
               end
            end
            ST_SPU_WAIT: begin
               cnt <= cnt - 1'b1;
               if (cnt_done) begin
                  spu_oe <= 1'b1; // [R21]
                  state <= ST_PULL;
                  ms_cnt <= CNT_W'(`SWM_CYC(1000));
               end
            end
            ST_PULL: begin
               ms_cnt <= ms_cnt - 1'b1;
               if (ms_cnt == '0) begin
                  ms_cnt <= CNT_W'(`SWM_CYC(1000));
                  if (hold_ms == 16'h0000) begin
                     spu_oe <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     hold_ms <= hold_ms - 16'h0001;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         req_ready <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE) || take_req;
         // A pending push may fill the buffer, so ready waits one cycle
         req_ready <= (state == ST_IDLE) && buf_ready && !out_push &&
                      !take_req;
      end
   end

   // Length of the current low drive, used to check the reset pulse
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         low_run <= '0;
      end else if (line_oe) begin
         low_run <= low_run + 1'b1;
      end else begin
         low_run <= '0;
      end
   end

   swm_skid #(
      .WIDTH($bits(swm_pkg::swm_rsp_t))
   ) u_skid (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(out_push),
      .in_ready(buf_ready),
      .in_data(out_word),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(rsp)
   );

   rst_low_len_a: assert property ( // [R1]
      @(posedge clock) disable iff (!arst_n)
      $rose(state == ST_RST_WAIT) |-> low_run >= C_RST)
      else $error("reset pulse too short");
   spu_no_drive_a: assert property ( // [R21]
      @(posedge clock) disable iff (!arst_n)
      spu_oe |-> !line_oe)
      else $error("line driven during strong pull");
   sample_in_win_a: assert property ( // [R13]
      @(posedge clock) disable iff (!arst_n)
      sample_now |-> is_read && slot_pos < CNT_W'(150))
      else $error("read sample outside window");
   w0_hold_a: assert property ( // [R7]
      @(posedge clock) disable iff (!arst_n)
      state == ST_SLOT && !is_read && !shreg[0] && !cnt_done
      |=> line_oe)
      else $error("write zero released early");
   rec_high_a: assert property ( // [R5]
      @(posedge clock) disable iff (!arst_n)
      state == ST_RECOVER && cnt != C_REC |-> !line_oe)
      else $error("line low during recovery");
   rd_release_a: assert property ( // [R13]
      @(posedge clock) disable iff (!arst_n)
      state == ST_SLOT && is_read && slot_pos > C_RDL |-> !line_oe)
      else $error("read slot still driven low");
   req_take_a: assert property ( // [R3]
      @(posedge clock) disable iff (!arst_n)
      take_req |=> busy && !req_ready)
      else $error("request not closed after take");
endmodule : swm_master

`default_nettype wire

// file: swm_master_bench.sv
/* Self-checking bench for swm_master facing the sensor model.
   Assumes the wire resolves from both low drivers through a pull-up. */
`timescale 1ns/1ps
`default_nettype none
`include "swm_cfg.svh"
module swm_master_bench;
   logic clock;
   logic arst_n;
   logic req_valid;
   logic req_ready;
   swm_pkg::swm_req_t req;
   logic rsp_valid;
   logic rsp_ready;
   swm_pkg::swm_rsp_t rsp;
   swm_pkg::swm_rsp_t got;
   logic line_oe;
   logic spu_oe;
   logic busy;
   logic pull_low;
   wire line_in;
   int miscompares;
   int num_checks;
   int cycles;
   int run;
   int last_run;
   assign line_in = (line_oe || pull_low) ? 1'b0 : 1'b1;
   swm_master u_dut (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp(rsp), .line_in(line_in),
      .line_oe(line_oe), .spu_oe(spu_oe), .busy(busy));
   swm_sensor_model u_sensor (.line(line_in), .pull_low(pull_low));
   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic send(input swm_pkg::swm_op_t op, input logic [7:0] d);
      @(negedge clock);
      req = '{op, d, 16'h0000};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      req_valid = 1'b0;
   endtask : send
   task automatic take;
      @(negedge clock);
      while (rsp_valid !== 1'b1) @(negedge clock);
      got = rsp;
      rsp_ready = 1'b1;
      @(negedge clock);
      rsp_ready = 1'b0;
   endtask : take
   task automatic do_reset;
      send(swm_pkg::SWM_OP_RESET, 8'h00);
      take;
      chk("presence", 16'h0001, {15'h0000, got.presence});
      chk("is_reset", 16'h0001, {15'h0000, got.is_reset});
      chk("reset low", 16'h0001, {15'h0000, last_run >= 4800});
   endtask : do_reset
   task automatic wr_byte(input logic [7:0] d);
      send(swm_pkg::SWM_OP_WRITE_BYTE, d);
   endtask : wr_byte
   task automatic rd_byte(input logic [7:0] e);
      send(swm_pkg::SWM_OP_READ_BYTE, 8'h00);
      take;
      chk("read byte", {8'h00, e}, {8'h00, got.data});
   endtask : rd_byte
   task automatic rd_bit(input logic e);
      send(swm_pkg::SWM_OP_READ_BIT, 8'h00);
      take;
      chk("read bit", {15'h0000, e}, {15'h0000, got.data[0]});
   endtask : rd_bit
   task automatic t_write_read;
      do_reset;
      wr_byte(`SWM_CMD_WRITE_PAD);
      wr_byte(8'h5A);
      wr_byte(8'hC3);
      wr_byte(8'h7F);
      do_reset;
      wr_byte(`SWM_CMD_READ_PAD);
      rd_byte(8'h10);
      rd_byte(8'h11);
      rd_byte(8'h5A);
      rd_byte(8'hC3);
      rd_byte(8'h7F);
      do_reset;
   endtask : t_write_read
   task automatic t_copy;
      int n;
      int bad;
      n = 0;
      bad = 0;
      wr_byte(`SWM_CMD_COPY_PAD);
      send(swm_pkg::SWM_OP_STRONG_PULL, 8'h00);
      while (spu_oe !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      chk("pull on", 16'h0001, {15'h0000, spu_oe});
      while (spu_oe === 1'b1) begin
         if (line_oe !== 1'b0) bad++;
         @(negedge clock);
      end
      chk("quiet line", 16'h0000, 16'(bad));
   endtask : t_copy
   task automatic t_reload_stall;
      do_reset;
      wr_byte(`SWM_CMD_RELOAD);
      send(swm_pkg::SWM_OP_READ_BIT, 8'h00);
      send(swm_pkg::SWM_OP_READ_BIT, 8'h00);
      while (busy === 1'b1) @(negedge clock);
      repeat (4) @(negedge clock);
      // Both buffer entries held, so no further request may be taken
      chk("ready full", 16'h0000, {15'h0000, req_ready});
      take;
      chk("reload busy", 16'h0000, {15'h0000, got.data[0]});
      take;
      chk("reload done", 16'h0001, {15'h0000, got.data[0]});
   endtask : t_reload_stall
   task automatic t_convert_power;
      do_reset;
      wr_byte(`SWM_CMD_CONVERT);
      rd_bit(1'b0);
      rd_bit(1'b0);
      rd_bit(1'b1);
      do_reset;
      wr_byte(`SWM_CMD_READ_POWER);
      rd_bit(1'b1);
   endtask : t_convert_power
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (line_oe === 1'b1) begin
         run <= run + 1;
      end else begin
         if (run != 0) last_run <= run;
         run <= 0;
      end
      // Whole sequence needs about 150k cycles; each reset alone is 9600
      if (cycles == 175000) begin
         miscompares++;
         wrap_up;
      end
   end
   initial begin
      arst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      rsp_ready = 1'b0;
      miscompares = 0;
      num_checks = 0;
      cycles = 0;
      run = 0;
      last_run = 0;
      repeat (16) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      t_write_read;
      t_copy;
      t_reload_stall;
      t_convert_power;
      wrap_up;
   end
endmodule : swm_master_bench
`default_nettype wire

// file: swm_pkg.sv
/*
 Types shared by the single-wire bus master.
 Assumes swm_cfg.svh is on the include path.
*/
`include "swm_cfg.svh"

package swm_pkg;
   typedef enum logic [2:0] {
      SWM_OP_RESET,
      SWM_OP_WRITE_BYTE,
      SWM_OP_READ_BYTE,
      SWM_OP_READ_BIT,
      SWM_OP_STRONG_PULL
   } swm_op_t;

   typedef struct packed {
      swm_op_t op;
      logic [7:0] data;
      logic [15:0] hold;
   } swm_req_t;

   typedef struct packed {
      logic presence;
      logic [7:0] data;
      logic is_reset;
   } swm_rsp_t;
endpackage : swm_pkg

// file: swm_sensor_model.sv
/* Behavioural sensor at the far end of the single-wire line.
   Assumes line is the resolved wire with a pull-up; delays in ns. */
`timescale 1ns/1ps
`default_nettype none
module swm_sensor_model #(
   parameter bit PARASITE = 1'b0
) (
   input wire logic line,
   output logic pull_low
);
   logic [7:0] pad [9];
   logic [7:0] nv [3];
   logic q [$];
   logic [23:0] sh;
   logic b;
   logic rd;
   int n;
   int wr;
   time t0;
   initial begin
      pull_low = 1'b0;
      n = 0;
      wr = 0;
      foreach (pad[i]) pad[i] = 8'h10 + 8'(i);
      foreach (nv[i]) nv[i] = 8'hA0 + 8'(i);
      forever begin
         @(negedge line);
         t0 = $time;
         rd = (q.size() > 0);
         if (rd) begin
            pull_low = !q.pop_front();
            #15000 pull_low = 1'b0;
         end else begin
            #30000 b = line;
         end
         wait (line === 1'b1);
         // A long low abandons whatever was in flight
         if ($time - t0 >= 480000) begin
            q.delete();
            n = 0;
            wr = 0;
            #30000 pull_low = 1'b1;
            #120000 pull_low = 1'b0;
         end else if (!rd) begin
            sh = {b, sh[23:1]};
            n++;
            if (wr != 0 && n == 24) begin
               pad[2] = sh[7:0];
               pad[3] = sh[15:8];
               pad[4] = sh[23:16];
               wr = 0;
               n = 0;
            end else if (wr == 0 && n == 8) begin
               n = 0;
               case (sh[23:16])
                  8'h4E: wr = 1;
                  8'hBE: begin
                     foreach (pad[i])
                        for (int k = 0; k < 8; k++) q.push_back(pad[i][k]);
                  end
                  8'h48: foreach (nv[i]) nv[i] = pad[i+2];
                  8'hB8: begin
                     foreach (nv[i]) pad[i+2] = nv[i];
                     q = {1'b0, 1'b1};
                  end
                  8'h44: q = {1'b0, 1'b0, 1'b1};
                  8'hB4: q.push_back(!PARASITE);
                  default: ;
               endcase
            end
         end
      end
   end
endmodule : swm_sensor_model
`default_nettype wire

// file: swm_skid.sv
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes a single clock; output stalls back-press the producer.
*/
`timescale 1ns/1ps
`default_nettype none

module swm_skid #(
   parameter int WIDTH = 10
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   buf_stall_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer output changed while stalled");
endmodule : swm_skid

`default_nettype wire
